// ==== hw/cti_engine.sv ====
// Invalidation engine: configuration cache and TLB arrays, command and broadcast
// invalidation, sync barrier and lookup for the translation path.
// Assumes commands arrive in queue order and fills come from a table walker.
module cti_engine (
  input wire logic clk, // 100 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic cmd_valid, // Command offered
  input wire cti_pkg::cti_cmd_s cmd, // Command fields
  output logic cmd_ready, // Engine can take a command
  output logic sync_done, // Sync consumed, one-cycle pulse
  output logic busy, // Command in progress
  input wire logic bcast_valid, // Broadcast TLB invalidation offered
  input wire cti_pkg::cti_cmd_s bcast, // Broadcast fields
  output logic bcast_ready, // Broadcast can be taken
  input wire logic wide_address_space_id_support, // 16-bit ASIDs
  input wire logic wide_vm_id_support, // 16-bit VMIDs
  input wire logic vm_id_wildcard_enable, // Widen VMID matching
  input wire logic [cti_pkg::ID_W-1:0] vm_id_wildcard_mask, // VMID bits ignored
  input wire logic cfg_fill_valid, // Config cache fill
  input wire logic [2:0] cfg_fill_idx, // Fill slot
  input wire cti_pkg::cti_cfg_s cfg_fill, // Fill data
  input wire logic tlb_fill_valid, // TLB fill
  input wire logic [2:0] tlb_fill_idx, // Fill slot
  input wire cti_pkg::cti_tlb_s tlb_fill, // Fill data
  input wire logic txn_start, // Transaction enters translation
  input wire logic txn_done, // Transaction visible to system
  input wire logic lookup_valid, // Lookup request
  input wire logic [1:0] lookup_sec, // Lookup security state
  input wire logic [cti_pkg::STREAM_W-1:0] lookup_stream, // Lookup stream tag
  input wire logic [cti_pkg::ID_W-1:0] lookup_vmid, // Lookup VMID
  input wire logic [cti_pkg::ID_W-1:0] lookup_asid, // Lookup ASID
  input wire logic [cti_pkg::VA_W-1:0] lookup_va, // Lookup address
  output logic lookup_ack, // Lookup answered, one-cycle pulse
  output logic cfg_hit, // Config stream entry present
  output logic tlb_hit // Leaf TLB entry present
);

  cti_pkg::cti_state_e state;
  cti_pkg::cti_state_e next_state;
  cti_pkg::cti_cmd_s cur;
  logic cur_bcast;
  cti_pkg::cti_cfg_s cfg_mem [cti_pkg::CFG_N];
  cti_pkg::cti_tlb_s tlb_mem [cti_pkg::TLB_N];
  logic [cti_pkg::INFL_W-1:0] in_flight;
  logic [cti_pkg::CFG_N-1:0] cfg_kill;
  logic [cti_pkg::TLB_N-1:0] tlb_kill;
  logic [cti_pkg::CFG_N-1:0] cfg_look;
  logic [cti_pkg::TLB_N-1:0] tlb_look;

  // Mask that drops the low range+1 tag bits; range 31 clears the whole mask
  function automatic logic [cti_pkg::STREAM_W-1:0] range_mask(input logic [4:0] r);
    logic [cti_pkg::STREAM_W:0] m;
    m = {(cti_pkg::STREAM_W+1){1'b1}} << ({1'b0, r} + 6'h01);
    return m[cti_pkg::STREAM_W-1:0];
  endfunction : range_mask

  // Address equality above the entry size
  function automatic logic va_match(input logic [cti_pkg::VA_W-1:0] a,
                                    input logic [cti_pkg::VA_W-1:0] b,
                                    input logic [cti_pkg::SHIFT_W-1:0] sh);
    logic [cti_pkg::VA_W-1:0] m;
    m = {cti_pkg::VA_W{1'b1}} << sh;
    return ((a ^ b) & m) == {cti_pkg::VA_W{1'b0}};
  endfunction : va_match

  // Identifier compare at the implemented width
  function automatic logic id_match(input logic [cti_pkg::ID_W-1:0] a,
                                    input logic [cti_pkg::ID_W-1:0] b,
                                    input logic wide,
                                    input logic [cti_pkg::ID_W-1:0] ignore);
    logic [cti_pkg::ID_W-1:0] m;
    m = wide ? ~ignore : ({{(cti_pkg::ID_W-cti_pkg::ID_NARROW_W){1'b0}},
                           {cti_pkg::ID_NARROW_W{1'b1}}} & ~ignore);
    return ((a ^ b) & m) == {cti_pkg::ID_W{1'b0}};
  endfunction : id_match

  // Upper identifier bits must be zero when only narrow ids exist
  function automatic logic id_ok(input logic [cti_pkg::ID_W-1:0] id, input logic wide);
    return wide || (id[cti_pkg::ID_W-1:cti_pkg::ID_NARROW_W] == 8'h00);
  endfunction : id_ok

  // Command decode
  wire logic cur_is_all = (cur.op == cti_pkg::CTI_OP_CFG_ALL) ||
                          ((cur.op == cti_pkg::CTI_OP_CFG_RANGE) &&
                           (cur.range == cti_pkg::RANGE_ALL));
  wire logic cur_is_range = (cur.op == cti_pkg::CTI_OP_CFG_RANGE) && !cur_is_all;
  wire logic cur_is_ste = (cur.op == cti_pkg::CTI_OP_CFG_STE);
  wire logic [1:0] cur_sec = cur.realm_queue ? cti_pkg::SEC_REALM
                                             : cur.security_state_select;
  wire logic [cti_pkg::STREAM_W-1:0] cur_mask = cur_is_ste ? {cti_pkg::STREAM_W{1'b1}}
                                                           : range_mask(cur.range);
  wire logic [cti_pkg::ID_W-1:0] wild = vm_id_wildcard_enable ? vm_id_wildcard_mask
                                                              : 16'h0000;
  wire logic ids_ok = id_ok(cur.vmid, wide_vm_id_support) &&
                      id_ok(cur.asid, wide_address_space_id_support);
  wire logic cmd_take = cmd_ready && cmd_valid && !bcast_valid;
  wire logic bcast_take = bcast_ready && bcast_valid;

  // Configuration cache kill vector, whole vector applied in one edge
  always_comb begin
    cfg_kill = '0;
    for (int i = 0; i < cti_pkg::CFG_N; i++) begin
      if (state == cti_pkg::CTI_ST_EXEC && !cur_bcast && cfg_mem[i].valid &&
          cfg_mem[i].sec == cur_sec) begin
        if (cur_is_all) begin
          cfg_kill[i] = 1'b1;
        end else if (cur_is_range || cur_is_ste) begin
          cfg_kill[i] = ((cfg_mem[i].stream ^ cur.requester_stream_tag) & cur_mask) ==
                        {cti_pkg::STREAM_W{1'b0}};
        end
      end
    end
  end

  // TLB kill vector; locked entries survive every invalidation
  always_comb begin
    tlb_kill = '0;
    for (int i = 0; i < cti_pkg::TLB_N; i++) begin
      if (state == cti_pkg::CTI_ST_EXEC && tlb_mem[i].valid && !tlb_mem[i].locked &&
          ids_ok && !(cur_bcast && tlb_mem[i].shared_set_flag)) begin
        case (cur.op)
          cti_pkg::CTI_OP_TLB_ALL: begin
            tlb_kill[i] = 1'b1;
          end
          cti_pkg::CTI_OP_TLB_VMALL: begin
            tlb_kill[i] = id_match(tlb_mem[i].vmid, cur.vmid, wide_vm_id_support, wild);
          end
          cti_pkg::CTI_OP_TLB_ASID: begin
            // Shared-set flag not consulted here
            tlb_kill[i] = id_match(tlb_mem[i].vmid, cur.vmid, wide_vm_id_support, wild) &&
                          id_match(tlb_mem[i].asid, cur.asid,
                                   wide_address_space_id_support, 16'h0000);
          end
          cti_pkg::CTI_OP_TLB_VA: begin
            tlb_kill[i] = id_match(tlb_mem[i].vmid, cur.vmid, wide_vm_id_support, wild) &&
                          id_match(tlb_mem[i].asid, cur.asid,
                                   wide_address_space_id_support, 16'h0000) &&
                          va_match(tlb_mem[i].va, cur.va, tlb_mem[i].size_shift) &&
                          (tlb_mem[i].leaf || !cur.leaf_only);
          end
          default: begin
            tlb_kill[i] = 1'b0;
          end
        endcase
      end
    end
  end

  // Lookup compare against current contents; retries see fresh state
  always_comb begin
    cfg_look = '0;
    tlb_look = '0;
    for (int i = 0; i < cti_pkg::CFG_N; i++) begin
      cfg_look[i] = cfg_mem[i].valid && cfg_mem[i].sec == lookup_sec &&
                    cfg_mem[i].kind == cti_pkg::CTI_KIND_STE &&
                    cfg_mem[i].stream == lookup_stream;
    end
    for (int i = 0; i < cti_pkg::TLB_N; i++) begin
      tlb_look[i] = tlb_mem[i].valid && tlb_mem[i].leaf && tlb_mem[i].vmid == lookup_vmid &&
                    tlb_mem[i].asid == lookup_asid &&
                    va_match(tlb_mem[i].va, lookup_va, tlb_mem[i].size_shift);
    end
  end

  // Sequencer: one command at a time, sync held until translations drain
  always_comb begin
    next_state = state;
    case (state)
      cti_pkg::CTI_ST_IDLE: begin
        if (bcast_take) begin
          next_state = cti_pkg::CTI_ST_EXEC;
        end else if (cmd_take) begin
          next_state = (cmd.op == cti_pkg::CTI_OP_SYNC) ? cti_pkg::CTI_ST_SYNC
                                                        : cti_pkg::CTI_ST_EXEC;
        end
      end
      cti_pkg::CTI_ST_EXEC: begin
        next_state = cti_pkg::CTI_ST_IDLE;
      end
      cti_pkg::CTI_ST_SYNC: begin
        if (in_flight == cti_pkg::INFL_ZERO) begin
          next_state = cti_pkg::CTI_ST_IDLE;
        end
      end
      default: begin
        next_state = cti_pkg::CTI_ST_IDLE;
      end
    endcase
  end

  // State, handshakes and captured command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= cti_pkg::CTI_ST_IDLE;
      cur <= '0;
      cur_bcast <= 1'b0;
      cmd_ready <= 1'b0;
      bcast_ready <= 1'b0;
      busy <= 1'b0;
      sync_done <= 1'b0;
    end else begin
      state <= next_state;
      if (bcast_take) begin
        cur <= bcast;
        cur_bcast <= 1'b1;
      end else if (cmd_take) begin
        cur <= cmd;
        cur_bcast <= 1'b0;
      end
      cmd_ready <= (next_state == cti_pkg::CTI_ST_IDLE);
      bcast_ready <= (next_state == cti_pkg::CTI_ST_IDLE);
      busy <= (next_state != cti_pkg::CTI_ST_IDLE);
      sync_done <= (state == cti_pkg::CTI_ST_SYNC) && (in_flight == cti_pkg::INFL_ZERO);
    end
  end

  // In-flight translation count; invalidations never stall or abort them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_flight <= cti_pkg::INFL_ZERO;
    end else if (txn_start && !txn_done) begin
      in_flight <= in_flight + cti_pkg::INFL_ONE;
    end else if (txn_done && !txn_start && in_flight != cti_pkg::INFL_ZERO) begin
      in_flight <= in_flight - cti_pkg::INFL_ONE;
    end
  end

  // Config cache: fill then kill in the same edge, kill wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < cti_pkg::CFG_N; i++) begin
        cfg_mem[i] <= '0;
      end
    end else begin
      for (int i = 0; i < cti_pkg::CFG_N; i++) begin
        if (cfg_kill[i]) begin
          cfg_mem[i].valid <= 1'b0;
        end else if (cfg_fill_valid && cfg_fill_idx == i[2:0]) begin
          cfg_mem[i] <= cfg_fill;
        end
      end
    end
  end

  // TLB: local clear only, nothing is forwarded to other agents
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < cti_pkg::TLB_N; i++) begin
        tlb_mem[i] <= '0;
      end
    end else begin
      for (int i = 0; i < cti_pkg::TLB_N; i++) begin
        if (tlb_kill[i]) begin
          tlb_mem[i].valid <= 1'b0;
        end else if (tlb_fill_valid && tlb_fill_idx == i[2:0]) begin
          tlb_mem[i] <= tlb_fill;
        end
      end
    end
  end

  // Registered lookup answer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lookup_ack <= 1'b0;
      cfg_hit <= 1'b0;
      tlb_hit <= 1'b0;
    end else begin
      lookup_ack <= lookup_valid;
      cfg_hit <= lookup_valid && (|cfg_look);
      tlb_hit <= lookup_valid && (|tlb_look);
    end
  end

endmodule : cti_engine

// ==== hw/cti_pkg.sv ====
// Constants, encodings and carriers for the configuration and TLB invalidation engine.
// Assumes one clock, commands handed over in queue order by a command-queue reader.
// Operation
// - Invalidate-all-configuration is handled as a stream range invalidation with range 31.
// - Range 31 ignores the stream tag and hits every tag of the security state.
// - Invalidate-all also drops virtual machine data, including VMID-indexed entries.
// - Invalidate-all clears stream, level-1, context and virtual machine cached kinds.
// - The full-range case uses a dedicated clear-everything path, no range compare.
// - Invalidate-all from a Realm queue touches Realm stream tags only.
// - Invalidations leave stalled transactions alone; software resumes or terminates them.
// - A retried stalled transaction is translated afresh against current cache contents.
// - In-flight transactions may finish with values looked up before invalidation.
// - Each invalidation is atomic to translations: no half-valid structure is seen.
// - Sync completes only after in-flight transactions using old structures are done.
// - Sync is consumed only after all earlier invalidations have completed.
// - TLB invalidations act locally and emit no broadcast to other agents.
// - Last-level scope invalidates only the matching leaf TLB entry.
// - Incoming broadcast TLB invalidations perform the equivalent local invalidation, sparing entries with the shared-set flag.
// - VMID wildcard enable widens matching of command and broadcast invalidations.
// - ASID and VMID are 8 or 16 bits by width flags; narrow upper bits reserved.
// - Narrow mode with non-zero upper identifier bits leaves TLB entries unaffected.
// - Command ASID matching ignores the shared-set flag of the entry.
// - At least the named scope is invalidated; locked entries are never touched.
// - Address match ignores low bits covered by the entry size.
// - Range covers an aligned block of 2^(range+1) tags, low bits ignored.
package cti_pkg;
  localparam int STREAM_W = 32;
  localparam int ID_W = 16;
  localparam int ID_NARROW_W = 8;
  localparam int VA_W = 48;
  localparam int SHIFT_W = 6;
  localparam int CFG_N = 8;
  localparam int TLB_N = 8;
  localparam int INFL_W = 8;
  localparam logic [4:0] RANGE_ALL = 5'h1F;
  localparam logic [1:0] SEC_SECURE = 2'h0;
  localparam logic [1:0] SEC_NONSECURE = 2'h1;
  localparam logic [1:0] SEC_REALM = 2'h2;
  localparam logic [INFL_W-1:0] INFL_ONE = 8'h01;
  localparam logic [INFL_W-1:0] INFL_ZERO = 8'h00;

  typedef enum logic [3:0] {
    CTI_OP_NOP = 4'h0,
    CTI_OP_CFG_STE = 4'h1,
    CTI_OP_CFG_RANGE = 4'h2,
    CTI_OP_CFG_ALL = 4'h3,
    CTI_OP_TLB_ALL = 4'h4,
    CTI_OP_TLB_VMALL = 4'h5,
    CTI_OP_TLB_ASID = 4'h6,
    CTI_OP_TLB_VA = 4'h7,
    CTI_OP_SYNC = 4'h8
  } cti_op_e;

  typedef enum logic [2:0] {
    CTI_KIND_STE = 3'h0,
    CTI_KIND_STREAM_TABLE_LEVEL1_DESCRIPTOR = 3'h1,
    CTI_KIND_CD = 3'h2,
    CTI_KIND_CONTEXT_TABLE_LEVEL1_DESCRIPTOR = 3'h3,
    CTI_KIND_VMS = 3'h4
  } cti_kind_e;

  typedef enum logic [1:0] {
    CTI_ST_IDLE = 2'h0,
    CTI_ST_EXEC = 2'h1,
    CTI_ST_SYNC = 2'h2
  } cti_state_e;

  typedef struct packed {
    cti_op_e op;
    logic [1:0] security_state_select;
    logic realm_queue;
    logic [STREAM_W-1:0] requester_stream_tag;
    logic [4:0] range;
    logic [ID_W-1:0] vmid;
    logic [ID_W-1:0] asid;
    logic [VA_W-1:0] va;
    logic leaf_only;
  } cti_cmd_s;

  typedef struct packed {
    logic valid;
    logic [1:0] sec;
    cti_kind_e kind;
    logic [STREAM_W-1:0] stream;
    logic [ID_W-1:0] vmid;
  } cti_cfg_s;

  typedef struct packed {
    logic valid;
    logic locked;
    logic shared_set_flag;
    logic leaf;
    logic [ID_W-1:0] vmid;
    logic [ID_W-1:0] asid;
    logic [VA_W-1:0] va;
    logic [SHIFT_W-1:0] size_shift;
  } cti_tlb_s;
endpackage : cti_pkg

// ==== tb/cti_engine_chk.sv ====
// Checker for engine handshakes, sync barrier and lookup timing.
// Assumes it is bound to every instance of the engine.
module cti_engine_chk (
  input wire logic clk, // Engine clock
  input wire logic rstn, // Async reset, active low
  input wire logic cmd_valid, // Command offered
  input wire cti_pkg::cti_cmd_s cmd, // Command fields
  input wire logic cmd_ready, // Engine idle
  input wire logic sync_done, // Sync consumed
  input wire logic busy, // Command in progress
  input wire logic bcast_valid, // Broadcast offered
  input wire logic bcast_ready, // Broadcast can be taken
  input wire logic txn_start, // Transaction enters
  input wire logic txn_done, // Transaction visible
  input wire logic lookup_valid, // Lookup request
  input wire logic lookup_ack, // Lookup answer
  input wire logic cfg_hit, // Config hit
  input wire logic tlb_hit // TLB hit
);
  logic [7:0] infl; // Mirror of the in-flight count
  wire take = cmd_valid && cmd_ready && !bcast_valid;
  wire is_sync = cmd.op == cti_pkg::CTI_OP_SYNC;
  wire is_inv = !is_sync && cmd.op != cti_pkg::CTI_OP_NOP;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // In-flight counter, a done at zero is ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) infl <= 8'h00;
    else if (txn_start && !txn_done) infl <= infl + 8'h01;
    else if (txn_done && !txn_start && infl != 8'h00) infl <= infl - 8'h01;
  end
  // Handshake, barrier and lookup timing
  inval_timing_a: assert property (
    take && is_inv |=> busy ##[1:2] cmd_ready && !busy)
    else $error("invalidation did not finish in time");
  bcast_timing_a: assert property (
    bcast_valid && bcast_ready |=> busy ##[1:2] bcast_ready)
    else $error("broadcast did not finish in time");
  busy_excl_a: assert property (busy |-> !cmd_ready && !bcast_ready)
    else $error("ready while busy");
  sync_wait_a: assert property (sync_done |-> $past(infl) == 8'h00)
    else $error("sync done with transactions in flight");
  sync_pulse_a: assert property (sync_done |=> !sync_done)
    else $error("sync done longer than one cycle");
  sync_after_busy_a: assert property (sync_done |-> $past(busy))
    else $error("sync done without a pending sync");
  sync_quick_a: assert property (
    take && is_sync && infl == 8'h00 && !txn_start |-> ##[2:3] sync_done)
    else $error("idle sync not consumed");
  ack_next_a: assert property (lookup_ack == $past(lookup_valid))
    else $error("lookup answer not one cycle later");
  hit_quiet_a: assert property (!lookup_ack |-> !cfg_hit && !tlb_hit)
    else $error("hit outside answer cycle");
  cover property (sync_done && $past(infl, 3) != 8'h00);
  cover property (bcast_valid && bcast_ready);
  cover property (lookup_ack && tlb_hit);
endmodule : cti_engine_chk

bind cti_engine cti_engine_chk cti_engine_chk_i (.clk, .rstn, .cmd_valid, .cmd, .cmd_ready,
  .sync_done, .busy, .bcast_valid, .bcast_ready, .txn_start, .txn_done, .lookup_valid,
  .lookup_ack, .cfg_hit, .tlb_hit);

// ==== tb/cti_sw_model.sv ====
// Software-side command issuer for the invalidation engine.
// Assumes the bench offers broadcasts only while no command is pending.
module cti_sw_model (
  input wire logic clk, // Engine clock
  input wire logic rstn, // Async reset, active low
  input wire logic req, // Issue request, one-cycle pulse
  input wire cti_pkg::cti_cmd_s req_cmd, // Command to issue
  input wire logic cmd_ready, // Engine idle
  input wire logic bcast_valid, // Broadcast wins the cycle
  output logic cmd_valid, // Command offered
  output cti_pkg::cti_cmd_s cmd, // Command, held while offered
  output logic taken // Command accepted, one-cycle pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // Issue in queue order and hold until taken; stale fields inverted after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
      cmd <= '0;
      taken <= 1'b0;
    end else begin
      taken <= cmd_valid && cmd_ready && !bcast_valid;
      if (req) begin
        cmd_valid <= 1'b1;
        cmd <= req_cmd;
      end else if (cmd_valid && cmd_ready && !bcast_valid) begin
        cmd_valid <= 1'b0;
        cmd <= ~cmd;
      end
    end
  end
endmodule : cti_sw_model

// ==== tb/test_cti_engine.sv ====
// Testbench for the invalidation engine: fills, commands, broadcasts, lookups.
// Assumes the software model issues commands; inputs change at falling edges.
module test_cti_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, req, taken, cmd_valid, cmd_ready, sync_done, busy, bcast_valid, bcast_ready;
  logic wide_address_space_id_support, wide_vm_id_support, vm_id_wildcard_enable, seen;
  logic cfg_fill_valid, tlb_fill_valid, txn_start, txn_done, lookup_valid, lookup_ack;
  logic cfg_hit, tlb_hit;
  logic [15:0] vm_id_wildcard_mask, lookup_vmid, lookup_asid;
  logic [2:0] cfg_fill_idx, tlb_fill_idx;
  logic [1:0] lookup_sec;
  logic [31:0] lookup_stream;
  logic [47:0] lookup_va;
  cti_pkg::cti_cmd_s cmd, bcast, req_cmd, c;
  cti_pkg::cti_cfg_s cfg_fill;
  cti_pkg::cti_tlb_s tlb_fill;
  int mismatches, samples_checked;
  cti_engine cti_engine_i (.clk, .rstn, .cmd_valid, .cmd, .cmd_ready, .sync_done, .busy,
    .bcast_valid, .bcast, .bcast_ready, .wide_address_space_id_support, .wide_vm_id_support,
    .vm_id_wildcard_enable, .vm_id_wildcard_mask, .cfg_fill_valid, .cfg_fill_idx, .cfg_fill,
    .tlb_fill_valid, .tlb_fill_idx, .tlb_fill, .txn_start, .txn_done, .lookup_valid,
    .lookup_sec, .lookup_stream, .lookup_vmid, .lookup_asid, .lookup_va, .lookup_ack,
    .cfg_hit, .tlb_hit);
  cti_sw_model cti_sw_model_i (.clk, .rstn, .req, .req_cmd, .cmd_ready, .bcast_valid,
    .cmd_valid, .cmd, .taken);
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic cti_pkg::cti_cmd_s mk(cti_pkg::cti_op_e op, logic [1:0] s,
    logic [31:0] sid, logic [4:0] rng, logic [15:0] vm, logic [15:0] as, logic [47:0] va);
    return '{op, s, 1'b0, sid, rng, vm, as, va, 1'b0};
  endfunction : mk
  task automatic idle();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("idle", 3'h1, {2'h0, cmd_ready});
  endtask : idle
  task automatic issue(input cti_pkg::cti_cmd_s x, input bit w);
    int n;
    n = 0;
    {req_cmd, req} = {x, 1'b1};
    @(negedge clk);
    req = 1'b0;
    while (taken !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("taken", 3'h1, {2'h0, taken});
    if (w) idle();
  endtask : issue
  task automatic bc(input cti_pkg::cti_cmd_s x);
    {bcast, bcast_valid} = {x, 1'b1};
    @(negedge clk);
    {bcast, bcast_valid} = {~x, 1'b0};
    idle();
    chk("bcast ready", 3'h1, {2'h0, bcast_ready});
  endtask : bc
  task automatic cput(input logic [2:0] i, input logic [1:0] s, input logic [31:0] sid);
    {cfg_fill_idx, cfg_fill, cfg_fill_valid} = {i, 1'b1, s, cti_pkg::CTI_KIND_STE, sid,
      16'h0001, 1'b1};
    @(negedge clk);
    cfg_fill_valid = 1'b0;
    @(negedge clk);
  endtask : cput
  task automatic tput(input logic [2:0] i, input logic lk, input logic ss, input logic [15:0] as,
    input logic [47:0] va);
    {tlb_fill_idx, tlb_fill, tlb_fill_valid} = {i, 3'h7 & {1'b1, lk, ss}, 1'b1, 16'h0001,
      as, va, 6'h0C, 1'b1};
    @(negedge clk);
    tlb_fill_valid = 1'b0;
    @(negedge clk);
  endtask : tput
  task automatic look(input string nm, input logic [1:0] s, input logic [31:0] sid,
    input logic [15:0] as, input logic [47:0] va, input logic [1:0] e);
    {lookup_sec, lookup_stream, lookup_vmid, lookup_asid, lookup_va} = {s, sid, 16'h0001, as, va};
    lookup_valid = 1'b1;
    @(negedge clk);
    lookup_valid = 1'b0;
    chk(nm, {1'b1, e}, {lookup_ack, cfg_hit, tlb_hit});
    @(negedge clk);
  endtask : look
  // Watchdog
  initial begin
    #200us;
    mismatches++;
    test_done();
  end
  // Main sequence
  initial begin
    {rstn, req, bcast_valid, cfg_fill_valid, tlb_fill_valid, txn_start, txn_done} = '0;
    {lookup_valid, vm_id_wildcard_enable, vm_id_wildcard_mask, bcast, req_cmd, c} = '0;
    {cfg_fill_idx, cfg_fill, tlb_fill_idx, tlb_fill, lookup_sec, lookup_stream} = '0;
    {lookup_vmid, lookup_asid, lookup_va, mismatches, samples_checked, seen} = '0;
    {wide_address_space_id_support, wide_vm_id_support} = 2'h3;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    // Invalidate-all by security state, then range 31 from a realm queue
    cput(3'h0, cti_pkg::SEC_NONSECURE, 32'h5);
    cput(3'h1, cti_pkg::SEC_SECURE, 32'h5);
    cput(3'h2, cti_pkg::SEC_REALM, 32'h7);
    c = mk(cti_pkg::CTI_OP_CFG_ALL, cti_pkg::SEC_NONSECURE, 32'h9, 5'h00, 0, 0, 0);
    issue(c, 1);
    look("all ns", cti_pkg::SEC_NONSECURE, 32'h5, 0, 0, 2'h0);
    look("all sec", cti_pkg::SEC_SECURE, 32'h5, 0, 0, 2'h2);
    cput(3'h0, cti_pkg::SEC_NONSECURE, 32'h5);
    c = mk(cti_pkg::CTI_OP_CFG_RANGE, cti_pkg::SEC_NONSECURE, 32'h1234, 5'h1F, 0, 0, 0);
    c.realm_queue = 1'b1;
    issue(c, 1);
    look("realm q ns", cti_pkg::SEC_NONSECURE, 32'h5, 0, 0, 2'h2);
    look("realm q realm", cti_pkg::SEC_REALM, 32'h7, 0, 0, 2'h0);
    // Aligned range of four tags, and a single entry
    cput(3'h0, cti_pkg::SEC_NONSECURE, 32'h10);
    cput(3'h1, cti_pkg::SEC_NONSECURE, 32'h13);
    cput(3'h2, cti_pkg::SEC_NONSECURE, 32'h14);
    c = mk(cti_pkg::CTI_OP_CFG_RANGE, cti_pkg::SEC_NONSECURE, 32'h12, 5'h01, 0, 0, 0);
    issue(c, 1);
    look("range lo", cti_pkg::SEC_NONSECURE, 32'h10, 0, 0, 2'h0);
    look("range hi", cti_pkg::SEC_NONSECURE, 32'h13, 0, 0, 2'h0);
    look("range out", cti_pkg::SEC_NONSECURE, 32'h14, 0, 0, 2'h2);
    c = mk(cti_pkg::CTI_OP_CFG_STE, cti_pkg::SEC_NONSECURE, 32'h14, 5'h00, 0, 0, 0);
    issue(c, 1);
    look("ste", cti_pkg::SEC_NONSECURE, 32'h14, 0, 0, 2'h0);
    // TLB: unaligned match, broadcast, shared-set flag, narrow ids, wildcard, locking
    tput(3'h0, 1'b0, 1'b1, 16'h0002, 48'h1000);
    tput(3'h1, 1'b1, 1'b0, 16'h0003, 48'h5000);
    tput(3'h2, 1'b0, 1'b0, 16'h0004, 48'h9000);
    look("va mid", 0, 0, 16'h0002, 48'h1ABC, 2'h1);
    bc(mk(cti_pkg::CTI_OP_TLB_ASID, 0, 0, 0, 16'h0001, 16'h0004, 0));
    look("bcast kill", 0, 0, 16'h0004, 48'h9000, 2'h0);
    bc(mk(cti_pkg::CTI_OP_TLB_ASID, 0, 0, 0, 16'h0001, 16'h0002, 0));
    look("bcast set", 0, 0, 16'h0002, 48'h1000, 2'h1);
    issue(mk(cti_pkg::CTI_OP_TLB_ASID, 0, 0, 0, 16'h0001, 16'h0002, 0), 1);
    look("asid set", 0, 0, 16'h0002, 48'h1000, 2'h0);
    tput(3'h2, 1'b0, 1'b0, 16'h0004, 48'h9000);
    {wide_address_space_id_support, wide_vm_id_support} = 2'h0;
    issue(mk(cti_pkg::CTI_OP_TLB_VMALL, 0, 0, 0, 16'h0101, 0, 0), 1);
    {wide_address_space_id_support, wide_vm_id_support} = 2'h3;
    look("narrow", 0, 0, 16'h0004, 48'h9000, 2'h1);
    {vm_id_wildcard_enable, vm_id_wildcard_mask} = {1'b1, 16'h00FF};
    issue(mk(cti_pkg::CTI_OP_TLB_VMALL, 0, 0, 0, 16'h0033, 0, 0), 1);
    vm_id_wildcard_enable = 1'b0;
    look("wildcard", 0, 0, 16'h0004, 48'h9000, 2'h0);
    tput(3'h3, 1'b0, 1'b0, 16'h0005, 48'h2000);
    c = mk(cti_pkg::CTI_OP_TLB_VA, 0, 0, 0, 16'h0001, 16'h0005, 48'h2FFF);
    c.leaf_only = 1'b1;
    issue(c, 1);
    look("leaf va", 0, 0, 16'h0005, 48'h2000, 2'h0);
    issue(mk(cti_pkg::CTI_OP_TLB_ALL, 0, 0, 0, 0, 0, 0), 1);
    look("locked", 0, 0, 16'h0003, 48'h5000, 2'h1);
    // Sync waits for an in-flight transaction
    txn_start = 1'b1;
    @(negedge clk);
    txn_start = 1'b0;
    issue(mk(cti_pkg::CTI_OP_SYNC, 0, 0, 0, 0, 0, 0), 0);
    repeat (6) begin
      @(negedge clk);
      seen = seen | sync_done;
    end
    chk("sync early", 3'h0, {2'h0, seen});
    chk("sync busy", 3'h1, {2'h0, busy});
    txn_done = 1'b1;
    @(negedge clk);
    txn_done = 1'b0;
    repeat (6) begin
      seen = seen | sync_done;
      @(negedge clk);
    end
    chk("sync late", 3'h1, {2'h0, seen});
    issue(mk(cti_pkg::CTI_OP_SYNC, 0, 0, 0, 0, 0, 0), 1);
    test_done();
  end
endmodule : test_cti_engine
